// File: watchdog_timer_tb.sv
// Self-checking testbench of the watchdog timer over its register bus.
`timescale 1ns/1ps
module watchdog_timer_tb;
  import wdg_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, rst_req, gate;
  logic [1:0] bresp, rresp;
  logic [DATA_W-1:0] rdata;
  logic [34:0] exp_q[$];
  logic [1:0] bq[$];
  logic [1:0] wr_exp = AXI_RESP_OKAY;
  logic [STRB_W-1:0] wstrb = WDG_FULL_STRB;
  logic [7:0] rnd = 8'h38;
  logic [31:0] rv;
  int err_count = 0, samples_checked = 0, n, resets;

  always #12.5 aclk = ~aclk;

  wdg_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .module_clock_gate(gate),
    .wdg_irq(irq), .wdg_reset_request(rst_req));
  wdg_sys_model i_sys (.aclk(aclk), .wdg_reset_request(rst_req), .module_clock_gate(gate), .resets_seen(resets));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  function logic [34:0] ok(input logic [31:0] d);
    return {1'b1, AXI_RESP_OKAY, d};
  endfunction : ok

  task check_rd(input logic [34:0] x, input logic [1:0] r, input logic [31:0] d);
    samples_checked++;
    if (r !== x[33:32] || (x[34] && d !== x[31:0])) begin
      err_count++;
      $display("CHECK FAILED at %0t: read %h/%h, expected %h", $time, r, d, x[33:0]);
    end
  endtask : check_rd

  task check_bit(input logic g, input logic x);
    samples_checked++;
    if (g !== x) begin
      err_count++;
      $display("CHECK FAILED at %0t: output level %b, expected %b", $time, g, x);
    end
  endtask : check_bit

  // Each task ends one edge after its last release, so the next one never drives a strobe twice in a step.
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic aw, w;
    bq.push_back(wr_exp);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && awready === 1'b1) begin aw = 1'b0; awvalid <= 1'b0; end
      if (w && wready === 1'b1) begin w = 1'b0; wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task rd(input logic [11:0] a, input logic [34:0] x);
    logic ar;
    exp_q.push_back(x);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    ar = 1'b1;
    while (ar) begin
      @(posedge aclk);
      if (arready === 1'b1) begin ar = 1'b0; arvalid <= 1'b0; end
    end
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  task wait_for(input logic sel, input int lim);
    n = 0;
    while (n < lim && (sel ? rst_req : irq) !== 1'b1) begin @(posedge aclk); n++; end
  endtask : wait_for

  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready === 1'b1) begin
      check_rd(exp_q.pop_front(), rresp, rdata);
    end
    if (bvalid === 1'b1 && bready === 1'b1) begin
      check_rd({1'b0, bq.pop_front(), 32'h0}, bresp, 32'h0);
    end
  end

  task wrap_up;
    $display("comparisons %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  initial begin
    #500000;
    err_count++;
    wrap_up;
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(WDG_OFS_RELOAD, ok(WDG_RELOAD_RST));
    rd(WDG_OFS_COUNT, ok(WDG_COUNT_RST));
    rd(WDG_OFS_CONTROL, ok(32'h0));
    rd(WDG_OFS_LOCK, ok(32'h0));
    rd(12'h018, {1'b0, AXI_RESP_SLVERR, 32'h0});
    $display("test reset_values done");
    rnd = lfsr(rnd);
    rv = {22'h0, rnd, 2'h0} + 32'h100;
    wr(WDG_OFS_RELOAD, rv);
    rd(WDG_OFS_RELOAD, ok(rv));
    rd(WDG_OFS_COUNT, ok(rv));
    i_sys.pulse(5);
    rd(WDG_OFS_COUNT, ok(rv));
    wr(WDG_OFS_CONTROL, 32'h1);
    rnd = lfsr(rnd);
    i_sys.pulse(rnd[3:0] + 1);
    rd(WDG_OFS_COUNT, ok(rv - rnd[3:0] - 32'h1));
    wr(WDG_OFS_IRQ_CLEAR, 32'h0);
    rd(WDG_OFS_COUNT, ok(rv));
    $display("test counting done");
    rv = 32'd1 * 32'd40;
    i_sys.hold(1'b1);
    repeat (5) wr(WDG_OFS_RELOAD, rv);
    check_bit(irq, 1'b0);
    wait_for(1'b0, 200);
    check_bit(irq, 1'b1);
    rd(WDG_OFS_MASKED, ok(32'h1));
    repeat (100) @(posedge aclk);
    check_bit(rst_req, 1'b0);
    rd(WDG_OFS_RAW, ok(32'h1));
    wr(WDG_OFS_IRQ_CLEAR, 32'h5);
    check_bit(irq, 1'b0);
    $display("test expiry done");
    wr(WDG_OFS_CONTROL, 32'h3);
    wait_for(1'b1, 300);
    check_bit(rst_req, 1'b1);
    rd(WDG_OFS_COUNT, ok(32'h0));
    check_bit(resets == 1, 1'b1);
    wr(WDG_OFS_CONTROL, 32'h1);
    check_bit(rst_req, 1'b0);
    wr(WDG_OFS_CONTROL, 32'h0);
    rd(WDG_OFS_MASKED, ok(32'h0));
    i_sys.hold(1'b0);
    $display("test reset_request done");
    wr(WDG_OFS_LOCK, 32'h0);
    rd(WDG_OFS_LOCK, ok(32'h1));
    wr(WDG_OFS_RELOAD, 32'h5);
    rd(WDG_OFS_RELOAD, ok(rv));
    wr(WDG_OFS_LOCK, WDG_UNLOCK_KEY);
    rd(WDG_OFS_LOCK, ok(32'h0));
    wr(WDG_OFS_RELOAD, 32'h5);
    rd(WDG_OFS_RELOAD, ok(32'h5));
    wstrb <= 4'h1;
    wr(WDG_OFS_RELOAD, 32'h000000AB);
    wstrb <= WDG_FULL_STRB;
    rd(WDG_OFS_RELOAD, ok(32'h000000AB));
    wstrb <= 4'h7;
    wr(WDG_OFS_LOCK, WDG_UNLOCK_KEY);
    wstrb <= WDG_FULL_STRB;
    rd(WDG_OFS_LOCK, ok(32'h1));
    wr(WDG_OFS_LOCK, WDG_UNLOCK_KEY);
    rd(WDG_OFS_LOCK, ok(32'h0));
    wr_exp = AXI_RESP_SLVERR;
    wr(12'h018, 32'h0);
    wr_exp = AXI_RESP_OKAY;
    $display("test lock done");
    wr(WDG_OFS_TEST_CTRL, 32'h1);
    wr(WDG_OFS_TEST_OUT, 32'h3);
    check_bit(irq, 1'b1);
    check_bit(rst_req, 1'b1);
    wr(WDG_OFS_TEST_CTRL, 32'h0);
    check_bit(irq, 1'b0);
    check_bit(rst_req, 1'b0);
    $display("test test_mode done");
    wrap_up;
  end
endmodule : watchdog_timer_tb

// File: wdg_axil.sv
// AXI4-Lite slave front end that turns bus transfers into register strobes.
`timescale 1ns/1ps
module wdg_axil (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address and data
  input wire logic [wdg_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [wdg_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [wdg_pkg::STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address and data
  input wire logic [wdg_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [wdg_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Register core side
  wdg_reg_if.bus rif
);
  import wdg_pkg::*;

  logic aw_full;
  logic w_full;

  // Address and data are held separately so they may arrive in either order.
  assign s_axi_awready = !aw_full;
  assign s_axi_wready = !w_full;
  assign rif.wr_en = aw_full && w_full && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign rif.rd_en = s_axi_arvalid && s_axi_arready;
  assign rif.rd_addr = s_axi_araddr;
  assign s_axi_rdata = rif.rd_data;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      rif.wr_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full <= 1'b1;
      rif.wr_addr <= s_axi_awaddr;
    end else if (rif.wr_en) begin
      aw_full <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full <= 1'b0;
      rif.wr_data <= '0;
      rif.wr_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full <= 1'b1;
      rif.wr_data <= s_axi_wdata;
      rif.wr_strb <= s_axi_wstrb;
    end else if (rif.wr_en) begin
      w_full <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_RESP_OKAY;
    end else if (rif.wr_en) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= rif.wr_err ? AXI_RESP_SLVERR : AXI_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= AXI_RESP_OKAY;
    end else if (rif.rd_en) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= rif.rd_err ? AXI_RESP_SLVERR : AXI_RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : wdg_axil

// File: wdg_counter.sv
// The 32-bit watchdog down-counter with load and step controls.
`timescale 1ns/1ps
module wdg_counter (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic load,
  input wire logic [wdg_pkg::DATA_W-1:0] load_value,
  input wire logic step,
  // State
  output logic [wdg_pkg::DATA_W-1:0] count,
  output logic at_zero
);
  import wdg_pkg::*;

  // A load always takes priority over a step in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= WDG_COUNT_RST;
    end else if (load) begin
      count <= load_value;
    end else if (step) begin
      count <= count - 32'h00000001;
    end
  end

  assign at_zero = (count == 32'h00000000);

endmodule : wdg_counter

// File: wdg_pkg.sv
// Shared constants, register map and state type of the watchdog timer.
package wdg_pkg;

  // ****************************************************************
  // Bus widths and responses
  // ****************************************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam logic [1:0] AXI_RESP_OKAY = 2'h0;
  localparam logic [1:0] AXI_RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] WDG_OFS_RELOAD = 12'h000;
  localparam logic [ADDR_W-1:0] WDG_OFS_COUNT = 12'h004;
  localparam logic [ADDR_W-1:0] WDG_OFS_CONTROL = 12'h008;
  localparam logic [ADDR_W-1:0] WDG_OFS_IRQ_CLEAR = 12'h00C;
  localparam logic [ADDR_W-1:0] WDG_OFS_RAW = 12'h010;
  localparam logic [ADDR_W-1:0] WDG_OFS_MASKED = 12'h014;
  localparam logic [ADDR_W-1:0] WDG_OFS_LOCK = 12'hC00;
  localparam logic [ADDR_W-1:0] WDG_OFS_TEST_CTRL = 12'hF00;
  localparam logic [ADDR_W-1:0] WDG_OFS_TEST_OUT = 12'hF04;

  // ****************************************************************
  // Field positions, reset values and key
  // ****************************************************************
  localparam int WDG_BIT_IRQ_EN = 0;
  localparam int WDG_BIT_RST_EN = 1;
  localparam int WDG_BIT_TEST_RESET = 0;
  localparam int WDG_BIT_TEST_IRQ = 1;
  localparam logic [DATA_W-1:0] WDG_RELOAD_RST = 32'hFFFFFFFF;
  localparam logic [DATA_W-1:0] WDG_COUNT_RST = 32'hFFFFFFFF;
  localparam logic [DATA_W-1:0] WDG_UNLOCK_KEY = 32'h1ACCE551;
  localparam logic WDG_LOCK_RST = 1'b0;
  localparam logic [STRB_W-1:0] WDG_FULL_STRB = 4'hF;

  // ****************************************************************
  // Counter states
  // ****************************************************************
  typedef enum logic [1:0] {
    WDG_ST_IDLE = 2'b00,
    WDG_ST_RUN = 2'b01,
    WDG_ST_HALT = 2'b10
  } wdg_state_t;

endpackage : wdg_pkg

// File: wdg_reg_if.sv
// Register access channel between the bus slave and the register core.
`timescale 1ns/1ps
interface wdg_reg_if;
  import wdg_pkg::*;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [STRB_W-1:0] wr_strb;
  logic wr_err;
  logic rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic rd_err;

  modport bus (
    output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
    input wr_err, rd_data, rd_err
  );
  modport regs (
    input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
    output wr_err, rd_data, rd_err
  );
endinterface : wdg_reg_if

// File: wdg_sys_model.sv
// Behavioural system control block and reset controller seen by the watchdog.
`timescale 1ns/1ps
module wdg_sys_model (
  // Clock
  input wire logic aclk,
  // Watchdog side
  input wire logic wdg_reset_request,
  output logic module_clock_gate,
  output int resets_seen
);
  logic prev;

  initial begin
    module_clock_gate = 1'b0;
    resets_seen = 0;
    prev = 1'b0;
  end

  // A reset controller acts on the rising request only, so a held request counts once.
  always @(posedge aclk) begin
    if (wdg_reset_request === 1'b1 && !prev) begin
      resets_seen <= resets_seen + 1;
    end
    prev <= (wdg_reset_request === 1'b1);
  end

  task hold(input logic v);
    module_clock_gate <= v;
  endtask : hold

  // Opens the gate for exactly n rising edges.
  task pulse(input int n);
    module_clock_gate <= 1'b1;
    repeat (n) @(posedge aclk);
    module_clock_gate <= 1'b0;
  endtask : pulse
endmodule : wdg_sys_model

// File: wdg_top.sv
// Watchdog timer top: register file, lock, expiry logic and reset request.
// What this block does
// - 32-bit down-counter started from reload value.
// - Running counter decrements by one each edge the module clock gate is open.
// - Pending interrupt at zero: request reset, stop.
// - Interrupt clear reloads counter, countdown continues.
// - Writing key to lock register unlocks writes.
// - Locked: writes to other registers ignored.
// - Any non-key lock write locks again.
// - Interrupt enable bit runs watchdog and interrupt.
// - Zero raises interrupt and masked status flag.
// - Any write to clear register clears flag.
// - Reset output disabled: expiry reloads, keeps counting.
// - Reload value is full 32-bit writable field.
// - Counting follows the module clock gate.
// - Lock read returns bit 0, one when locked.
// - Masked status is raw status AND enable.
// - Reload write restarts countdown from new value.
// - Control bit enables reset output to system.
`timescale 1ns/1ps
module wdg_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [wdg_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [wdg_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [wdg_pkg::STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [wdg_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [wdg_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // System side
  input wire logic module_clock_gate,
  output logic wdg_irq,
  output logic wdg_reset_request
);
  import wdg_pkg::*;

  // ****************************************************************
  // Bus slave and counter
  // ****************************************************************
  wdg_reg_if rif ();

  logic [DATA_W-1:0] reload_value;
  logic [DATA_W-1:0] current_count;
  logic [DATA_W-1:0] merged_reload;
  logic irq_enable_bit;
  logic reset_output_enable;
  logic raw_irq_flag;
  logic masked_irq_flag;
  logic write_locked;
  logic reset_pending;
  logic test_mode;
  logic test_irq;
  logic test_reset;
  logic count_zero;
  logic count_load;
  logic count_step;
  logic expire;
  logic expire_reset;
  wdg_state_t state;
  wdg_state_t next_state;
  logic [ADDR_W-1:0] wr_word;
  logic [ADDR_W-1:0] rd_word;
  logic wr_mapped;
  logic wr_allowed;
  logic wr_reload;
  logic wr_control;
  logic irq_clear_write;
  logic wr_lock;
  logic wr_test_ctrl;
  logic wr_test_out;
  logic key_match;

  wdg_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .rif(rif.bus)
  );

  wdg_counter u_counter (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(count_load),
    .load_value(merged_reload),
    .step(count_step),
    .count(current_count),
    .at_zero(count_zero)
  );

  // ****************************************************************
  // Write decode and lock
  // ****************************************************************
  assign wr_word = {rif.wr_addr[ADDR_W-1:2], 2'b00};
  assign rd_word = {rif.rd_addr[ADDR_W-1:2], 2'b00};

  always_comb begin
    case (wr_word)
      WDG_OFS_RELOAD, WDG_OFS_COUNT, WDG_OFS_CONTROL, WDG_OFS_IRQ_CLEAR,
      WDG_OFS_RAW, WDG_OFS_MASKED, WDG_OFS_LOCK, WDG_OFS_TEST_CTRL,
      WDG_OFS_TEST_OUT: wr_mapped = 1'b1;
      default: wr_mapped = 1'b0;
    endcase
  end

  // Only the lock register stays writable while locked, so a runaway program cannot
  // switch the watchdog off.
  assign wr_allowed = rif.wr_en && wr_mapped && (!write_locked || wr_word == WDG_OFS_LOCK);
  assign rif.wr_err = !wr_mapped;
  assign wr_reload = wr_allowed && wr_word == WDG_OFS_RELOAD;
  assign wr_control = wr_allowed && wr_word == WDG_OFS_CONTROL;
  assign irq_clear_write = wr_allowed && wr_word == WDG_OFS_IRQ_CLEAR;
  assign wr_lock = wr_allowed && wr_word == WDG_OFS_LOCK;
  assign wr_test_ctrl = wr_allowed && wr_word == WDG_OFS_TEST_CTRL;
  assign wr_test_out = wr_allowed && wr_word == WDG_OFS_TEST_OUT;
  // A partial write never matches the key, so it locks.
  assign key_match = rif.wr_strb == WDG_FULL_STRB && rif.wr_data == WDG_UNLOCK_KEY;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      write_locked <= WDG_LOCK_RST;
    end else if (wr_lock) begin
      write_locked <= !key_match;
    end
  end

  // ****************************************************************
  // Reload value with byte strobes
  // ****************************************************************
  for (genvar b = 0; b < STRB_W; b++) begin : g_merge
    assign merged_reload[8*b+7:8*b] = (wr_reload && rif.wr_strb[b]) ?
      rif.wr_data[8*b+7:8*b] : reload_value[8*b+7:8*b];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload_value <= WDG_RELOAD_RST;
    end else if (wr_reload) begin
      reload_value <= merged_reload;
    end
  end

  // ****************************************************************
  // Control and test registers
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_enable_bit <= 1'b0;
      reset_output_enable <= 1'b0;
    end else if (wr_control && rif.wr_strb[0]) begin
      irq_enable_bit <= rif.wr_data[WDG_BIT_IRQ_EN];
      reset_output_enable <= rif.wr_data[WDG_BIT_RST_EN];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      test_mode <= 1'b0;
      test_irq <= 1'b0;
      test_reset <= 1'b0;
    end else begin
      if (wr_test_ctrl && rif.wr_strb[0]) begin
        test_mode <= rif.wr_data[0];
      end
      if (wr_test_out && rif.wr_strb[0]) begin
        test_irq <= rif.wr_data[WDG_BIT_TEST_IRQ];
        test_reset <= rif.wr_data[WDG_BIT_TEST_RESET];
      end
    end
  end

  // ****************************************************************
  // Countdown state machine
  // ****************************************************************
  assign expire = state == WDG_ST_RUN && module_clock_gate && count_zero;
  assign expire_reset = expire && raw_irq_flag && reset_output_enable;
  // Reload on a reload write, a clear write, or an expiry that does not end in reset.
  assign count_load = wr_reload || irq_clear_write || (expire && !expire_reset);
  assign count_step = state == WDG_ST_RUN && module_clock_gate && !count_zero;

  always_comb begin
    next_state = state;
    case (state)
      WDG_ST_IDLE: begin
        if (irq_enable_bit) begin
          next_state = WDG_ST_RUN;
        end
      end
      WDG_ST_RUN: begin
        if (!irq_enable_bit) begin
          next_state = WDG_ST_IDLE;
        end else if (expire_reset) begin
          next_state = WDG_ST_HALT;
        end
      end
      WDG_ST_HALT: begin
        // A halted counter restarts only when software reloads it, writes the clear register or drops the reset enable.
        if (wr_reload || irq_clear_write || !reset_output_enable) begin
          next_state = irq_enable_bit ? WDG_ST_RUN : WDG_ST_IDLE;
        end
      end
      default: begin
        next_state = WDG_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= WDG_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************************************
  // Interrupt flag and reset request
  // ****************************************************************
  // An expiry in the same cycle as a clear write keeps the flag set.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      raw_irq_flag <= 1'b0;
    end else if (expire) begin
      raw_irq_flag <= 1'b1;
    end else if (irq_clear_write) begin
      raw_irq_flag <= 1'b0;
    end
  end

  assign masked_irq_flag = raw_irq_flag && irq_enable_bit;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reset_pending <= 1'b0;
    end else if (!reset_output_enable) begin
      reset_pending <= 1'b0;
    end else if (expire_reset) begin
      reset_pending <= 1'b1;
    end else if (state == WDG_ST_HALT && next_state != WDG_ST_HALT) begin
      reset_pending <= 1'b0;
    end
  end

  assign wdg_irq = test_mode ? test_irq : masked_irq_flag;
  // Gating by the enable drops the request in the same cycle that software clears the enable.
  assign wdg_reset_request = test_mode ? test_reset : (reset_pending && reset_output_enable);

  // ****************************************************************
  // Read path
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rif.rd_data <= '0;
    end else if (rif.rd_en) begin
      case (rd_word)
        WDG_OFS_RELOAD: rif.rd_data <= reload_value;
        WDG_OFS_COUNT: rif.rd_data <= current_count;
        WDG_OFS_CONTROL: rif.rd_data <= {30'h00000000, reset_output_enable, irq_enable_bit};
        WDG_OFS_RAW: rif.rd_data <= {31'h00000000, raw_irq_flag};
        WDG_OFS_MASKED: rif.rd_data <= {31'h00000000, masked_irq_flag};
        WDG_OFS_LOCK: rif.rd_data <= {31'h00000000, write_locked};
        WDG_OFS_TEST_CTRL: rif.rd_data <= {31'h00000000, test_mode};
        WDG_OFS_TEST_OUT: rif.rd_data <= {30'h00000000, test_irq, test_reset};
        default: rif.rd_data <= '0;
      endcase
    end
  end

  always_comb begin
    case (rd_word)
      WDG_OFS_RELOAD, WDG_OFS_COUNT, WDG_OFS_CONTROL, WDG_OFS_IRQ_CLEAR,
      WDG_OFS_RAW, WDG_OFS_MASKED, WDG_OFS_LOCK, WDG_OFS_TEST_CTRL,
      WDG_OFS_TEST_OUT: rif.rd_err = 1'b0;
      default: rif.rd_err = 1'b1;
    endcase
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  count_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (count_step && !count_load) |=> current_count == $past(current_count) - 32'h00000001)
    else $error("Running counter did not step down by one.");

  halt_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
    expire_reset |=> (state == WDG_ST_HALT && wdg_reset_request == !test_mode) ##1
    ($stable(current_count) || $past(wr_reload || irq_clear_write)))
    else $error("Second expiry did not halt with a reset request.");

  clear_reload_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (irq_clear_write && !expire) |=> (current_count == reload_value && !raw_irq_flag))
    else $error("Clear write did not reload the counter and clear the flag.");

  key_unlock_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_lock && key_match) |=> !write_locked)
    else $error("Key write left the registers locked.");

  locked_ignore_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (write_locked && rif.wr_en && wr_word == WDG_OFS_CONTROL) |=>
    ($stable(irq_enable_bit) && $stable(reset_output_enable)))
    else $error("Control changed while locked.");

  relock_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (rif.wr_en && wr_word == WDG_OFS_LOCK && !key_match) |=> write_locked ##1 write_locked || $past(wr_lock))
    else $error("Non-key lock write did not lock.");

  expire_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    expire |=> raw_irq_flag && (masked_irq_flag == irq_enable_bit))
    else $error("Expiry did not raise the interrupt flag.");

  soft_expire_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (expire && !reset_output_enable && !wr_reload) |=> (current_count == reload_value && !wdg_reset_request || test_mode))
    else $error("Expiry without reset enable did not reload.");

  masked_and_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !test_mode |-> wdg_irq == (raw_irq_flag && irq_enable_bit))
    else $error("Interrupt output differs from raw AND enable.");

  reload_restart_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_reload |=> current_count == $past(merged_reload))
    else $error("Reload write did not restart the countdown.");

  no_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!reset_output_enable && !test_mode) |-> !wdg_reset_request)
    else $error("Reset request with reset output disabled.");

endmodule : wdg_top
